/* rtl/dcc_pkg.sv */
// Purpose: constants shared by the dual comparator control block
// Assumes: AHB-Lite register access, one aligned 32-bit word per register
// Notes: only the low byte of each register is implemented
//
// How it works
// [RQ1] read racing result change may miss flag
// [RQ2] software waits bias settling before enabling interrupts
// [RQ3] enabled comparator keeps running during sleep
// [RQ4] output change wakes when enables set
// [RQ5] wake always; service only with global enable
// [RQ6] reset restores all comparator registers
// [RQ7] bit 7 enables comparator, reset off
// [RQ8] bit 6 result, polarity corrected, read-only
// [RQ9] bit 5 drives result onto pin
// [RQ10] bit 4 inverts the result
// [RQ11] bit 2 picks reference or positive pin
// [RQ12] bits 1:0 pick negative input pin
// [RQ13] bit 3 reads zero, ignores writes
// [RQ14] pin driven only with drive, enable, output
// [RQ15] analog pins read zero on port
// [RQ16] comparator 2 gates Timer1 when selected
// [RQ17] software sets sync when gating Timer1
// [RQ18] capture comparator 2 on Timer1 falling edge
// [RQ19] capture uses the prescaled Timer1 clock
// [RQ20] control read copies result into reference latch
// [RQ21] flag set on mismatch rising edge
// [RQ22] aux bit1 gate source, bit0 sync enable
// [RQ23] two-stage synchroniser on each comparator result

package dcc_pkg;

   // ***************************************************************
   // register byte offsets
   // ***************************************************************
   localparam logic [7:0] OFS_CMP1_CTRL = 8'h00; // cmp1_control
   localparam logic [7:0] OFS_CMP2_CTRL = 8'h04; // cmp2_control
   localparam logic [7:0] OFS_CMP2_AUX = 8'h08; // cmp2_aux_control
   localparam logic [7:0] OFS_FLAGS = 8'h0C; // periph_flag_reg
   localparam logic [7:0] OFS_IRQ_EN = 8'h10; // enables for irq and wake
   localparam logic [7:0] OFS_ANALOG_SEL = 8'h14; // pins used as analog
   localparam logic [7:0] OFS_PORT = 8'h18; // port pin levels, read-only
   localparam logic [7:0] OFS_PIN_DIR = 8'h1C; // pin_direction of output pins

   // ***************************************************************
   // field positions
   // ***************************************************************
   localparam int CTL_ENABLE = 7;
   localparam int CTL_RESULT = 6;
   localparam int CTL_PIN_DRIVE = 5;
   localparam int CTL_INVERT = 4;
   localparam int CTL_REF_SEL = 2;
   localparam int CTL_NEG_SEL_LO = 0;
   localparam int AUX_MIRROR1 = 7;
   localparam int AUX_MIRROR2 = 6;
   localparam int AUX_GATE_SRC = 1;
   localparam int AUX_SYNC_EN = 0;
   localparam int IEN_PERIPH = 6;
   localparam int IEN_GLOBAL = 7;

   // writable bits of a control register, bit 3 and 6 excluded
   localparam logic [7:0] CTL_WR_MASK = 8'hB7;

   // ***************************************************************
   // reset values
   // ***************************************************************
   localparam logic [7:0] RST_CTRL = 8'h00;
   localparam logic [1:0] RST_AUX = 2'h2; // gate pin selected, no sync
   localparam logic [1:0] RST_FLAGS = 2'h0;
   localparam logic [7:0] RST_IRQ_EN = 8'h00;
   localparam logic [1:0] RST_PIN_DIR = 2'h3; // pins start as inputs

   // ***************************************************************
   // timing
   // ***************************************************************
   localparam int CLK_PERIOD_NS = 100;
   localparam int BIAS_SETTLE_NS = 1000;
   localparam int BIAS_SETTLE_CYC = (BIAS_SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

   // bus slave states, one-hot
   typedef enum logic [3:0] {
      BUS_IDLE = 4'h1,
      BUS_WRITE = 4'h2,
      BUS_RD_WAIT = 4'h4,
      BUS_RD_DATA = 4'h8
   } dcc_bus_state_t;

endpackage

/* rtl/dcc_top.sv */
// Purpose: control and status logic for two analog comparators
// Assumes: single 10 MHz clock, AHB-Lite slave, sole slave on the bus
// Notes: comparator raw outputs are asynchronous and resynchronised here

`timescale 1ns/1ps

module dcc_top
   import dcc_pkg::*;
#(
   parameter int PORT_W = 8
) (
   input wire logic ref_clk,
   input wire logic reset_n,
   input wire logic clk_en,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic hreadyout,
   output logic hresp,
   output logic [31:0] hrdata,
   input wire logic [1:0] cmp_raw,
   output logic [1:0] cmp_enable,
   output logic [1:0] cmp_ref_select,
   output logic [1:0] cmp1_neg_input_select,
   output logic [1:0] cmp2_neg_input_select,
   output logic [1:0] cmp_pin_out,
   output logic [1:0] cmp_pin_oe,
   input wire logic [PORT_W-1:0] port_pins,
   input wire logic sleeping,
   output logic wake_req,
   output logic irq_req,
   input wire logic tmr1_gate_pin,
   input wire logic tmr1_on,
   input wire logic tmr1_gate_enable,
   input wire logic tmr1_prescaled_clk,
   output logic tmr1_count_gate
);

   // ***************************************************************
   // elaboration check
   // ***************************************************************
   generate
      if (PORT_W < 1 || PORT_W > 8) begin : g_bad_width
         $error("PORT_W must be 1 to 8");
      end
   endgenerate

   // ***************************************************************
   // state declarations
   // ***************************************************************
   logic [7:0] ctrl_ff [2]; // control registers, result bit unused here
   logic [1:0] aux_ff; // gate source select and sync enable
   logic [1:0] flag_ff; // cmp_irq_flag per comparator
   logic [7:0] irq_en_ff; // cmp_irq_enable, periph and global enables
   logic [PORT_W-1:0] analog_sel_ff; // 1 marks an analog pin
   logic [1:0] pin_dir_ff; // pin_direction, 0 = output
   logic [1:0] sync1_ff; // first synchroniser stage
   logic [1:0] sync2_ff; // second synchroniser stage
   logic [1:0] result_ff; // cmp_result, sampled every clock
   logic [1:0] ref_ff; // mismatch reference latch
   logic [1:0] mism_d_ff; // delayed mismatch for edge detect
   logic t1clk_prev_ff; // prescaled Timer1 clock, last sample
   logic cmp2_synced_ff; // cmp2_synced_result
   dcc_bus_state_t state_ff; // bus slave state
   dcc_bus_state_t nxt_state;
   logic [7:0] addr_ff; // latched address phase offset
   logic [31:0] hrdata_ff; // read data
   logic [31:0] nxt_rdata;

   // ***************************************************************
   // bus decode
   // ***************************************************************
   logic accept; // address phase taken this cycle
   logic wr_now; // write data phase, hwdata valid
   logic rd_now; // read data captured this cycle
   logic [1:0] ctrl_access; // control register read or write per comparator
   logic [1:0] mismatch;
   logic [1:0] flag_set;
   logic t1clk_fall;
   logic gate_src;

   assign accept = hsel & hready & htrans[1];
   assign wr_now = (state_ff == BUS_WRITE);
   assign rd_now = (state_ff == BUS_RD_WAIT);

   // a write reloads the reference just as a read does, so both clear the mismatch
   assign ctrl_access[0] = (wr_now | rd_now) & (addr_ff == OFS_CMP1_CTRL); // RQ21
   assign ctrl_access[1] = (wr_now | rd_now) & (addr_ff == OFS_CMP2_CTRL); // RQ21

   // one wait state on reads so a preceding write is already visible
   assign hreadyout = (state_ff != BUS_RD_WAIT);
   assign hresp = 1'b0; // always OKAY, unmapped included
   assign hrdata = hrdata_ff;

   // next bus state
   always_comb begin
      nxt_state = state_ff;
      case (state_ff)
         BUS_RD_WAIT: begin
            nxt_state = BUS_RD_DATA;
         end
         BUS_IDLE, BUS_WRITE, BUS_RD_DATA: begin
            if (accept) begin
               nxt_state = hwrite ? BUS_WRITE : BUS_RD_WAIT;
            end else begin
               nxt_state = BUS_IDLE;
            end
         end
         default: begin
            nxt_state = BUS_IDLE;
         end
      endcase
   end

   // bus state and address phase capture
   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         state_ff <= BUS_IDLE;
         addr_ff <= 8'h00;
      end else if (clk_en) begin
         state_ff <= nxt_state;
         if (accept && hreadyout) begin
            addr_ff <= {haddr[7:2], 2'b00}; // upper address bits ignored
         end
      end
   end

   // ***************************************************************
   // read mux
   // ***************************************************************
   always_comb begin
      nxt_rdata = 32'h0000_0000; // unmapped reads as zero
      case (addr_ff)
         OFS_CMP1_CTRL, OFS_CMP2_CTRL: begin
            // bit 3 has no storage and reads zero
            nxt_rdata[7:0] = ctrl_ff[addr_ff[2]] & CTL_WR_MASK; // RQ13
            nxt_rdata[CTL_RESULT] = result_ff[addr_ff[2]]; // RQ8
         end
         OFS_CMP2_AUX: begin
            // mirror copies, reading here leaves the mismatch alone
            nxt_rdata[AUX_MIRROR1] = result_ff[0];
            nxt_rdata[AUX_MIRROR2] = result_ff[1];
            nxt_rdata[AUX_GATE_SRC] = aux_ff[1]; // RQ22
            nxt_rdata[AUX_SYNC_EN] = aux_ff[0]; // RQ22
         end
         OFS_FLAGS: begin
            nxt_rdata[1:0] = flag_ff;
         end
         OFS_IRQ_EN: begin
            nxt_rdata[7:0] = irq_en_ff;
         end
         OFS_ANALOG_SEL: begin
            nxt_rdata[PORT_W-1:0] = analog_sel_ff;
         end
         OFS_PORT: begin
            nxt_rdata[PORT_W-1:0] = port_pins & ~analog_sel_ff; // RQ15
         end
         OFS_PIN_DIR: begin
            nxt_rdata[1:0] = pin_dir_ff;
         end
         default: begin
            nxt_rdata = 32'h0000_0000;
         end
      endcase
   end

   // read data register, loaded in the wait cycle
   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         hrdata_ff <= 32'h0000_0000;
      end else if (clk_en && rd_now) begin
         hrdata_ff <= nxt_rdata;
      end
   end

   // ***************************************************************
   // software registers
   // ***************************************************************
   // configuration writes; reset puts both comparators off
   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         ctrl_ff[0] <= RST_CTRL; // RQ6
         ctrl_ff[1] <= RST_CTRL; // RQ6
         aux_ff <= RST_AUX; // RQ6
         irq_en_ff <= RST_IRQ_EN;
         analog_sel_ff <= '0;
         pin_dir_ff <= RST_PIN_DIR;
      end else if (clk_en && wr_now) begin
         case (addr_ff)
            OFS_CMP1_CTRL: begin
               ctrl_ff[0] <= hwdata[7:0] & CTL_WR_MASK; // RQ13
            end
            OFS_CMP2_CTRL: begin
               ctrl_ff[1] <= hwdata[7:0] & CTL_WR_MASK; // RQ13
            end
            OFS_CMP2_AUX: begin
               aux_ff <= hwdata[1:0]; // RQ22
            end
            OFS_IRQ_EN: begin
               irq_en_ff <= hwdata[7:0];
            end
            OFS_ANALOG_SEL: begin
               analog_sel_ff <= hwdata[PORT_W-1:0];
            end
            OFS_PIN_DIR: begin
               pin_dir_ff <= hwdata[1:0];
            end
            default: begin
               // flags are written in the flag block; read-only or unmapped, write dropped
            end
         endcase
      end
   end

   // ***************************************************************
   // comparator control outputs
   // ***************************************************************
   // enables are not gated by sleep, so an enabled comparator stays on
   assign cmp_enable = {ctrl_ff[1][CTL_ENABLE], ctrl_ff[0][CTL_ENABLE]}; // RQ7 RQ3
   assign cmp_ref_select = {ctrl_ff[1][CTL_REF_SEL], ctrl_ff[0][CTL_REF_SEL]}; // RQ11
   assign cmp1_neg_input_select = ctrl_ff[0][CTL_NEG_SEL_LO+:2]; // RQ12
   assign cmp2_neg_input_select = ctrl_ff[1][CTL_NEG_SEL_LO+:2]; // RQ12

   // ***************************************************************
   // per-comparator result, mismatch and flag
   // ***************************************************************
   genvar gi;
   generate
      for (gi = 0; gi < 2; gi++) begin : g_cmp
         // two stages; the first is only read by the second
         always_ff @(posedge ref_clk or negedge reset_n) begin
            if (!reset_n) begin
               sync1_ff[gi] <= 1'b0;
               sync2_ff[gi] <= 1'b0;
            end else if (clk_en) begin
               sync1_ff[gi] <= cmp_raw[gi]; // RQ23
               sync2_ff[gi] <= sync1_ff[gi]; // RQ23
            end
         end

         // sampling latch, updated every clock with polarity applied
         always_ff @(posedge ref_clk or negedge reset_n) begin
            if (!reset_n) begin
               result_ff[gi] <= 1'b0;
            end else if (clk_en) begin
               result_ff[gi] <= sync2_ff[gi] ^ ctrl_ff[gi][CTL_INVERT]; // RQ8 RQ10 RQ20
            end
         end

         // reference latch follows the result only on a control access
         always_ff @(posedge ref_clk or negedge reset_n) begin
            if (!reset_n) begin
               ref_ff[gi] <= 1'b0;
            end else if (clk_en && ctrl_access[gi]) begin
               ref_ff[gi] <= result_ff[gi]; // RQ20
            end
         end

         assign mismatch[gi] = ref_ff[gi] ^ result_ff[gi]; // RQ20

         // edge of the mismatch, not its level, raises the flag
         always_ff @(posedge ref_clk or negedge reset_n) begin
            if (!reset_n) begin
               mism_d_ff[gi] <= 1'b0;
            end else if (clk_en) begin
               mism_d_ff[gi] <= mismatch[gi];
            end
         end

         // a change landing with a read gets a flag here only if no mismatch is
         // pending; with one pending the mismatch stays high across the read and no flag is set
         assign flag_set[gi] = mismatch[gi] & ~mism_d_ff[gi]; // RQ21 RQ1

         // software writes the flag; a hardware set wins over a clear
         always_ff @(posedge ref_clk or negedge reset_n) begin
            if (!reset_n) begin
               flag_ff[gi] <= RST_FLAGS[gi];
            end else if (clk_en) begin
               if (flag_set[gi]) begin
                  flag_ff[gi] <= 1'b1; // RQ21
               end else if (wr_now && addr_ff == OFS_FLAGS) begin
                  flag_ff[gi] <= hwdata[gi];
               end
            end
         end

         // pin driven only when drive, enable and output direction agree
         assign cmp_pin_oe[gi] = ctrl_ff[gi][CTL_PIN_DRIVE] & ctrl_ff[gi][CTL_ENABLE]
                                 & ~pin_dir_ff[gi]; // RQ9 RQ14
         assign cmp_pin_out[gi] = result_ff[gi]; // RQ9
      end
   endgenerate

   // ***************************************************************
   // wake and interrupt request
   // ***************************************************************
   logic flag_active; // some enabled flag set with peripheral enable
   assign flag_active = |(flag_ff & irq_en_ff[1:0]) & irq_en_ff[IEN_PERIPH];
   // wake needs no global enable; the core runs the next instruction
   assign wake_req = sleeping & flag_active; // RQ4
   // vectoring only follows when global enable is also set
   assign irq_req = flag_active & irq_en_ff[IEN_GLOBAL]; // RQ5

   // ***************************************************************
   // Timer1 gate from comparator 2
   // ***************************************************************
   // the prescaled clock is sampled; counting happens on its rising edge
   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         t1clk_prev_ff <= 1'b0;
      end else if (clk_en) begin
         t1clk_prev_ff <= tmr1_prescaled_clk; // RQ19
      end
   end

   assign t1clk_fall = t1clk_prev_ff & ~tmr1_prescaled_clk; // RQ18

   // capture on the falling edge so the gate is stable at the increment
   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         cmp2_synced_ff <= 1'b0;
      end else if (clk_en && t1clk_fall) begin
         cmp2_synced_ff <= result_ff[1]; // RQ18 RQ19
      end
   end

   // without sync the gate follows the result directly and may glitch a count
   assign gate_src = aux_ff[1] ? tmr1_gate_pin
                   : (aux_ff[0] ? cmp2_synced_ff : result_ff[1]); // RQ16 RQ17
   assign tmr1_count_gate = tmr1_on & (~tmr1_gate_enable | gate_src); // RQ16

   // ***************************************************************
   // assertions
   // ***************************************************************
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!reset_n);

   pin_off_disabled_a: assert property (!cmp_enable[0] |-> !cmp_pin_oe[0]) // RQ14
      else $error("comparator 1 pin driven while disabled");

   flag_on_edge_a: assert property (clk_en && mismatch[1] && !mism_d_ff[1] |=> flag_ff[1]) // RQ21
      else $error("mismatch edge did not set flag");

   ref_on_read_a: assert property (clk_en && ctrl_access[0] |=> ref_ff[0] == $past(result_ff[0])) // RQ20
      else $error("control access did not reload reference latch");

   wake_needs_en_a: assert property (wake_req |-> sleeping && irq_en_ff[IEN_PERIPH]) // RQ4
      else $error("wake without peripheral enable");

   irq_global_a: assert property (!irq_en_ff[IEN_GLOBAL] |-> !irq_req) // RQ5
      else $error("interrupt request without global enable");

   bit3_zero_a: assert property (state_ff == BUS_RD_DATA && addr_ff == OFS_CMP1_CTRL
                                 |-> !hrdata[3]) // RQ13
      else $error("unimplemented control bit read nonzero");

   gate_cmp2_a: assert property (!aux_ff[1] && !aux_ff[0] && tmr1_on && tmr1_gate_enable
                                 |-> tmr1_count_gate == result_ff[1]) // RQ16
      else $error("Timer1 gate not following comparator 2");

   sync_capture_a: assert property (clk_en && t1clk_fall
                                    |=> cmp2_synced_ff == $past(result_ff[1])) // RQ18
      else $error("comparator 2 not captured on falling edge");

   // clock enable and raw level held over the whole three-stage path
   sync_delay_a: assert property ((clk_en && $stable(cmp_raw[0])) [*4]
                                  ##0 $stable(ctrl_ff[0])
                                  |-> result_ff[0] == (cmp_raw[0] ^ ctrl_ff[0][CTL_INVERT])) // RQ23
      else $error("result not settled after synchroniser");

   read_wait_a: assert property (accept && !hwrite && hreadyout && clk_en
                                 |=> !hreadyout ##1 hreadyout) // RQ20
      else $error("read wait state length wrong");

   flag_set_c: cover property (clk_en && flag_set[0]);
   read_ctrl_c: cover property (state_ff == BUS_RD_DATA && addr_ff == OFS_CMP2_CTRL);
   wake_c: cover property (wake_req && !irq_req);
   gate_sync_c: cover property (!aux_ff[1] && aux_ff[0] && t1clk_fall && tmr1_count_gate);

endmodule

/* verification/dcc_analog_model.sv */
// Purpose: comparator cores and Timer1 prescaler seen by the control block
// Assumes: logic levels stand in for analog voltages
// Notes: a disabled core drives low, as the analog side would
`timescale 1ns/1ps
module dcc_analog_model (
   input wire logic ref_clk,
   input wire logic reset_n,
   input wire logic [1:0] cmp_enable,
   input wire logic [1:0] cmp_ref_select,
   input wire logic [1:0] cmp1_neg_input_select,
   input wire logic [1:0] cmp2_neg_input_select,
   input wire logic [1:0] pos_pin_level,
   input wire logic vref_level,
   input wire logic [3:0] neg_pin_level,
   output logic [1:0] cmp_raw,
   output logic tmr1_prescaled_clk
);
   // ***************************************************************
   // input muxes and cores
   // ***************************************************************
   logic [1:0] vin_pos; // non-inverting input after reference mux
   logic [1:0] vin_neg; // inverting input after channel mux
   logic [3:0] presc_ff; // divide by 16, slow enough to see the latch
   always_comb begin
      vin_pos[0] = cmp_ref_select[0] ? vref_level : pos_pin_level[0];
      vin_pos[1] = cmp_ref_select[1] ? vref_level : pos_pin_level[1];
      vin_neg[0] = neg_pin_level[cmp1_neg_input_select];
      vin_neg[1] = neg_pin_level[cmp2_neg_input_select];
      // core runs whenever enabled, sleep or not
      cmp_raw = cmp_enable & vin_pos & ~vin_neg;
   end
   // timer clock after the prescaler
   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         presc_ff <= 4'h0;
      end else begin
         presc_ff <= presc_ff + 4'h1;
      end
   end
   assign tmr1_prescaled_clk = presc_ff[3];
endmodule

/* verification/dcc_top_bench.sv */
// Purpose: self-checking bench for the dual comparator control block
// Assumes: sole AHB-Lite slave, hready tied to hreadyout
// Notes: analog levels come from the bench through the core model
`timescale 1ns/1ps
module dcc_top_bench;
   import dcc_pkg::*;
   logic ref_clk, reset_n, clk_en, hsel, hwrite, sleeping;
   logic [31:0] haddr, hwdata, hrdata;
   logic [1:0] htrans, cmp_raw, cmp_enable, cmp_ref_select, cmp_pin_out, cmp_pin_oe;
   logic [2:0] hsize;
   logic [1:0] nsel1, nsel2, pos_lvl;
   logic [3:0] neg_lvl;
   logic [7:0] port_pins;
   logic hreadyout, hresp, wake_req, irq_req, vref_lvl, t1_pin, t1_on, t1_gen, t1_clk, t1_gate;
   wire logic hready;
   int mismatches, n_tests, cyc;
   assign hready = hreadyout; // one slave: its ready is the bus ready
   dcc_top #(.PORT_W(8)) u_dut (.ref_clk(ref_clk), .reset_n(reset_n), .clk_en(clk_en),
      .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
      .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout), .hresp(hresp),
      .hrdata(hrdata), .cmp_raw(cmp_raw), .cmp_enable(cmp_enable),
      .cmp_ref_select(cmp_ref_select), .cmp1_neg_input_select(nsel1),
      .cmp2_neg_input_select(nsel2), .cmp_pin_out(cmp_pin_out), .cmp_pin_oe(cmp_pin_oe),
      .port_pins(port_pins), .sleeping(sleeping), .wake_req(wake_req), .irq_req(irq_req),
      .tmr1_gate_pin(t1_pin), .tmr1_on(t1_on), .tmr1_gate_enable(t1_gen),
      .tmr1_prescaled_clk(t1_clk), .tmr1_count_gate(t1_gate));
   dcc_analog_model u_model (.ref_clk(ref_clk), .reset_n(reset_n), .cmp_enable(cmp_enable),
      .cmp_ref_select(cmp_ref_select), .cmp1_neg_input_select(nsel1),
      .cmp2_neg_input_select(nsel2), .pos_pin_level(pos_lvl), .vref_level(vref_lvl),
      .neg_pin_level(neg_lvl), .cmp_raw(cmp_raw), .tmr1_prescaled_clk(t1_clk));
   // ***************************************************************
   // bus and compare tasks
   // ***************************************************************
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_tests++;
      if (got !== exp) begin
         mismatches++;
         $display("unexpected value at %0t: got %h, wanted %h", $time, got, exp);
      end
   endtask
   // signals move by nba at a rising edge; ready and read data are taken at a rising edge
   task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] d,
      output logic [31:0] q);
      hsel <= 1'b1;
      haddr <= {24'h0, a};
      hwrite <= w;
      htrans <= 2'h2;
      do begin
         @(posedge ref_clk);
      end while (hready !== 1'b1);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= d;
      do begin
         @(posedge ref_clk);
      end while (hready !== 1'b1);
      q = hrdata;
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] q;
      bus(a, 1'b1, d, q);
   endtask
   task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
      logic [31:0] q;
      bus(a, 1'b0, 32'h0, q);
      chk(q, exp);
   endtask
   // port checks run at an edge and see what settled in the cycle before it
   task automatic pchk(input logic [31:0] got, input logic [31:0] exp);
      chk(got, exp);
   endtask
   task automatic idle(input int n);
      repeat (n) @(posedge ref_clk);
   endtask
   task automatic summarize();
      if (mismatches == 0 && n_tests > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask
   // ***************************************************************
   // clock, timeout and scenarios
   // ***************************************************************
   initial begin
      ref_clk = 1'b0;
      forever #50 ref_clk = ~ref_clk;
   end
   // a hang counts against the run
   always @(posedge ref_clk) begin
      cyc++;
      if (cyc == 5000) begin
         mismatches++;
         summarize();
      end
   end
   initial begin
      logic [7:0] v;
      logic res;
      {reset_n, hsel, hwrite, sleeping, t1_pin, t1_on, t1_gen} = 7'h0;
      {haddr, hwdata, htrans, port_pins, pos_lvl, neg_lvl} = '0;
      clk_en = 1'b1;
      hsize = 3'h2;
      vref_lvl = 1'b1;
      idle(8);
      reset_n <= 1'b1;
      idle(1);
      rd_chk(OFS_CMP1_CTRL, 32'h0);
      rd_chk(OFS_CMP2_AUX, 32'h2);
      rd_chk(OFS_PIN_DIR, 32'h3);
      rd_chk(8'h20, 32'h0); // unmapped place reads zero
      wr(OFS_CMP1_CTRL, 32'h48);
      rd_chk(OFS_CMP1_CTRL, 32'h0);
      // every invert, reference and channel code on both comparators
      neg_lvl <= 4'h2;
      for (int k = 0; k < 32; k++) begin
         v = {1'b1, 2'b00, k[3], 1'b0, k[2], k[1:0]};
         res = k[3] ^ (k[2] & (k[1:0] != 2'h1));
         wr(k[4] ? OFS_CMP2_CTRL : OFS_CMP1_CTRL, {24'h0, v});
         idle(4);
         rd_chk(k[4] ? OFS_CMP2_CTRL : OFS_CMP1_CTRL, {24'h0, v | (8'(res) << 6)});
         pchk({28'h0, cmp_enable[k[4]], cmp_ref_select[k[4]], k[4] ? nsel2 : nsel1},
            {28'h0, 1'b1, k[2], k[1:0]});
      end
      // mismatch flag is set on the edge only
      wr(OFS_CMP2_CTRL, 32'h0);
      wr(OFS_CMP1_CTRL, 32'h84);
      neg_lvl <= 4'h0;
      idle(BIAS_SETTLE_CYC);
      rd_chk(OFS_CMP1_CTRL, 32'hC4);
      wr(OFS_FLAGS, 32'h0);
      rd_chk(OFS_FLAGS, 32'h0);
      neg_lvl <= 4'h1;
      idle(6);
      rd_chk(OFS_FLAGS, 32'h1);
      wr(OFS_FLAGS, 32'h0);
      idle(6);
      rd_chk(OFS_FLAGS, 32'h0);
      sleeping <= 1'b1;
      wr(OFS_IRQ_EN, 32'h41);
      neg_lvl <= 4'h0;
      idle(6);
      rd_chk(OFS_FLAGS, 32'h0);
      neg_lvl <= 4'h1;
      idle(6);
      pchk({30'h0, wake_req, irq_req}, 32'h2);
      wr(OFS_IRQ_EN, 32'hC1);
      idle(1);
      pchk({31'h0, irq_req}, 32'h1);
      sleeping <= 1'b0;
      // pin drive needs drive, enable and output direction
      wr(OFS_PIN_DIR, 32'h0);
      idle(1);
      pchk({31'h0, cmp_pin_oe[0]}, 32'h0);
      wr(OFS_CMP1_CTRL, 32'hB4);
      idle(4);
      pchk({30'h0, cmp_pin_oe[0], cmp_pin_out[0]}, 32'h3);
      wr(OFS_CMP1_CTRL, 32'h34);
      idle(1);
      pchk({31'h0, cmp_pin_oe[0]}, 32'h0);
      wr(OFS_CMP1_CTRL, 32'hB4);
      wr(OFS_PIN_DIR, 32'h1);
      idle(1);
      pchk({31'h0, cmp_pin_oe[0]}, 32'h0);
      wr(OFS_ANALOG_SEL, 32'h0F);
      port_pins <= 8'hFF;
      idle(2);
      rd_chk(OFS_PORT, 32'hF0);
      // timer gate from pin, then live and latched comparator 2
      {t1_on, t1_gen, t1_pin} <= 3'h7;
      wr(OFS_CMP2_AUX, 32'h2);
      pchk({31'h0, t1_gate}, 32'h1);
      t1_pin <= 1'b0;
      idle(1);
      pchk({31'h0, t1_gate}, 32'h0);
      wr(OFS_CMP2_AUX, 32'h0);
      wr(OFS_CMP2_CTRL, 32'h84);
      idle(5);
      pchk({31'h0, t1_gate}, 32'h0);
      neg_lvl <= 4'h0;
      idle(5);
      pchk({31'h0, t1_gate}, 32'h1);
      rd_chk(OFS_CMP2_AUX, 32'h40);
      wr(OFS_CMP2_AUX, 32'h1);
      @(negedge t1_clk);
      @(posedge t1_clk);
      @(posedge ref_clk);
      neg_lvl <= 4'h1;
      idle(5);
      pchk({31'h0, t1_gate}, 32'h1);
      idle(8);
      pchk({31'h0, t1_gate}, 32'h0);
      reset_n <= 1'b0;
      idle(2);
      reset_n <= 1'b1;
      idle(1);
      rd_chk(OFS_CMP2_CTRL, 32'h0);
      rd_chk(OFS_CMP2_AUX, 32'h2);
      pchk({30'h0, cmp_enable}, 32'h0);
      summarize();
   end
endmodule
